/* core/dtc_map.svh */
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
// register byte addresses (word aligned)
`define DTC_OFF_CTRL   12'h000
`define DTC_OFF_MODE   12'h004
`define DTC_OFF_LOA    12'h008
`define DTC_OFF_LOB    12'h00C
`define DTC_OFF_HIA    12'h010
`define DTC_OFF_HIB    12'h014
`define DTC_OFF_CTRL2  12'h018
`define DTC_OFF_IEN    12'h01C
// timer_control_reg fields
`define DTC_CTRL_FLAG_B 7
`define DTC_CTRL_RUN_B  6
`define DTC_CTRL_FLAG_A 5
`define DTC_CTRL_RUN_A  4
// timer_mode_reg field bases for timer b (timer a = base + 4)
`define DTC_MODE_GATE  3
`define DTC_MODE_CSEL  2
`define DTC_MODE_MHI   1
`define DTC_MODE_MLO   0
// second_timer_control_reg fields
`define DTC_CTRL2_FAST_A 2
`define DTC_CTRL2_TOG_A  0
// first_interrupt_enable_reg fields
`define DTC_IEN_ETA    1
`define DTC_IEN_ETB    3
// reset values
`define DTC_RST_BYTE   8'h00
// prescale divide count
`define DTC_PRE_DIV    4'hC
`endif

/* core/dtc_pkg.sv */
package dtc_pkg;
	// per-timer configuration bundle
	typedef struct packed {
		logic [1:0] mode;
		logic       counter_sel;
		logic       gate;
		logic       run;
		logic       fast_clk;
		logic       toggle_en;
	} dtc_cfg_t;
	// decoded mode
	typedef enum logic [1:0] {
		DTC_M13, DTC_M16, DTC_M8R, DTC_MSPLIT
	} dtc_mode_t;
endpackage

/* core/dtc_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser plus falling edge detect
module dtc_sync (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// pin in
	input  wire logic pin_in,
	// synchronised level and edge
	output logic      level,
	output logic      fall
);
	logic s1_q;   // first stage, read only by s2
	logic s2_q;   // second stage
	logic s3_q;   // previous sample for edge detect
	// synchroniser chain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign level = s2_q;
	assign fall  = s3_q & ~s2_q;
endmodule
`default_nettype wire

/* core/dtc_timer.sv */
`timescale 1ns/1ns
`default_nettype none
// one timer channel: prescaler, gating and count modes
module dtc_timer
	import dtc_pkg::*;
(
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// configuration
	input  wire dtc_cfg_t   cfg,
	// synchronised pins
	input  wire logic       gate_lvl,
	input  wire logic       pin_fall,
	// software writes
	input  wire logic       wr_lo,
	input  wire logic       wr_hi,
	input  wire logic [7:0] wdata,
	// state
	output logic [7:0]      lo,
	output logic [7:0]      hi,
	output logic            ovf,
	output logic            pin_out
);
`include "dtc_map.svh"
	logic [3:0] pre_q;     // divide-by-12 counter
	logic       tick;      // one count event
	logic       enabled;   // run and gate ok
	logic [7:0] lo_q;
	logic [7:0] hi_q;
	logic       tog_q;
	logic [13:0] sum13;
	logic [16:0] sum16;
	logic [8:0]  sum8;
	// prescaler runs freely; phase is not tied to run
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pre_q <= 4'h0;
		else if (pre_q == `DTC_PRE_DIV - 4'h1)
			pre_q <= 4'h0;
		else
			pre_q <= pre_q + 4'h1;
	end
	assign enabled = cfg.run & (~cfg.gate | gate_lvl);
	always_comb begin
		if (cfg.counter_sel)
			tick = pin_fall;
		else if (cfg.fast_clk)
			tick = 1'b1;
		else
			tick = (pre_q == `DTC_PRE_DIV - 4'h1);
	end
	assign sum13 = {1'b0, hi_q, lo_q[4:0]} + 14'h1;
	assign sum16 = {1'b0, hi_q, lo_q} + 17'h1;
	assign sum8  = {1'b0, lo_q} + 9'h1;
	// count registers; software write wins over counting
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lo_q <= `DTC_RST_BYTE;
			hi_q <= `DTC_RST_BYTE;
		end else if (wr_lo || wr_hi) begin
			if (wr_lo)
				lo_q <= wdata;
			if (wr_hi)
				hi_q <= wdata;
		end else if (enabled && tick) begin
			unique case (dtc_mode_t'(cfg.mode))
				DTC_M13: begin
					lo_q <= {lo_q[7:5], sum13[4:0]};
					hi_q <= sum13[12:5];
				end
				DTC_M16: begin
					lo_q <= sum16[7:0];
					hi_q <= sum16[15:8];
				end
				DTC_M8R, DTC_MSPLIT: begin
					// split mode not supported: behaves as mode 2
					lo_q <= sum8[8] ? hi_q : sum8[7:0];
				end
			endcase
		end
	end
	// overflow pulse per mode
	always_comb begin
		unique case (dtc_mode_t'(cfg.mode))
			DTC_M13: ovf = enabled & tick & sum13[13];
			DTC_M16: ovf = enabled & tick & sum16[16];
			DTC_M8R, DTC_MSPLIT: ovf = enabled & tick & sum8[8];
		endcase
		if (wr_lo || wr_hi)
			ovf = 1'b0;
	end
	// compare toggle output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tog_q <= 1'b0;
		else if (cfg.toggle_en && ovf)
			tog_q <= ~tog_q;
	end
	assign lo      = lo_q;
	assign hi      = hi_q;
	assign pin_out = tog_q;
endmodule
`default_nettype wire

/* core/dtc_top.sv */
`timescale 1ns/1ns
`default_nettype none
// dual timer/counter with ahb-lite register slave
module dtc_top
	import dtc_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// count pins (two-way)
	input  wire logic        pin_a_in,
	output logic             pin_a_out,
	output logic             pin_a_oe,
	input  wire logic        pin_b_in,
	output logic             pin_b_out,
	output logic             pin_b_oe,
	// gate inputs
	input  wire logic        gate_a_in,
	input  wire logic        gate_b_in,
	// interrupt requests
	output logic             irq_a,
	output logic             irq_b
);
`include "dtc_map.svh"
	logic [7:0]  ctrl_q;   // timer_control_reg
	logic [7:0]  mode_q;   // timer_mode_reg
	logic [3:0]  ctrl2_q;  // second_timer_control_reg
	logic [7:0]  ien_q;    // first_interrupt_enable_reg
	logic        wr_q;     // pending write data phase
	logic [11:0] addr_q;   // latched address
	logic        we;       // write strobe
	logic        cnt_a_lvl, cnt_a_fall, cnt_b_lvl, cnt_b_fall;
	logic        gate_a_lvl, gate_b_lvl;
	logic [7:0]  lo_a, hi_a, lo_b, hi_b;
	logic        ovf_a, ovf_b;
	logic        tog_a, tog_b;
	dtc_cfg_t    cfg_a, cfg_b;
	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q   <= 1'b0;
			addr_q <= 12'h000;
		end else if (hready) begin
			wr_q   <= hsel & htrans[1] & hwrite;
			addr_q <= haddr;
		end
	end
	assign we        = wr_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	// synchronisers; count pin echoes our drive when compare is on in timer mode
	dtc_sync u_sca (.hclk(hclk), .hresetn(hresetn), .pin_in(pin_a_in),
		.level(cnt_a_lvl), .fall(cnt_a_fall));
	dtc_sync u_scb (.hclk(hclk), .hresetn(hresetn), .pin_in(pin_b_in),
		.level(cnt_b_lvl), .fall(cnt_b_fall));
	dtc_sync u_sga (.hclk(hclk), .hresetn(hresetn), .pin_in(gate_a_in),
		.level(gate_a_lvl), .fall());
	dtc_sync u_sgb (.hclk(hclk), .hresetn(hresetn), .pin_in(gate_b_in),
		.level(gate_b_lvl), .fall());
	// configuration bundles
	always_comb begin
		cfg_a.mode        = mode_q[`DTC_MODE_MHI+4:`DTC_MODE_MLO+4];
		cfg_a.counter_sel = mode_q[`DTC_MODE_CSEL+4];
		cfg_a.gate        = mode_q[`DTC_MODE_GATE+4];
		cfg_a.run         = ctrl_q[`DTC_CTRL_RUN_A];
		cfg_a.fast_clk    = ctrl2_q[`DTC_CTRL2_FAST_A];
		cfg_a.toggle_en   = ctrl2_q[`DTC_CTRL2_TOG_A];
		cfg_b.mode        = mode_q[`DTC_MODE_MHI:`DTC_MODE_MLO];
		cfg_b.counter_sel = mode_q[`DTC_MODE_CSEL];
		cfg_b.gate        = mode_q[`DTC_MODE_GATE];
		cfg_b.run         = ctrl_q[`DTC_CTRL_RUN_B];
		cfg_b.fast_clk    = ctrl2_q[`DTC_CTRL2_FAST_A+1];
		cfg_b.toggle_en   = ctrl2_q[`DTC_CTRL2_TOG_A+1];
	end
	// timer a uses upper nibble of the mode register
	dtc_timer u_ta (.hclk(hclk), .hresetn(hresetn), .cfg(cfg_a),
		.gate_lvl(gate_a_lvl), .pin_fall(cnt_a_fall),
		.wr_lo(we && addr_q == `DTC_OFF_LOA),
		.wr_hi(we && addr_q == `DTC_OFF_HIA),
		.wdata(hwdata[7:0]), .lo(lo_a), .hi(hi_a),
		.ovf(ovf_a), .pin_out(tog_a));
	dtc_timer u_tb (.hclk(hclk), .hresetn(hresetn), .cfg(cfg_b),
		.gate_lvl(gate_b_lvl), .pin_fall(cnt_b_fall),
		.wr_lo(we && addr_q == `DTC_OFF_LOB),
		.wr_hi(we && addr_q == `DTC_OFF_HIB),
		.wdata(hwdata[7:0]), .lo(lo_b), .hi(hi_b),
		.ovf(ovf_b), .pin_out(tog_b));
	// control register; hardware overflow set beats software clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ctrl_q <= `DTC_RST_BYTE;
		else begin
			if (we && addr_q == `DTC_OFF_CTRL)
				ctrl_q <= hwdata[7:0];
			if (ovf_a)
				ctrl_q[`DTC_CTRL_FLAG_A] <= 1'b1;
			if (ovf_b)
				ctrl_q[`DTC_CTRL_FLAG_B] <= 1'b1;
		end
	end
	// mode, prescale/compare and enable registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q  <= `DTC_RST_BYTE;
			ctrl2_q <= 4'h0;
			ien_q   <= `DTC_RST_BYTE;
		end else if (we) begin
			if (addr_q == `DTC_OFF_MODE)
				mode_q <= hwdata[7:0];
			if (addr_q == `DTC_OFF_CTRL2)
				ctrl2_q <= hwdata[3:0];
			if (addr_q == `DTC_OFF_IEN)
				ien_q <= hwdata[7:0];
		end
	end
	// interrupt requests follow flag gated by enable
	assign irq_a = ctrl_q[`DTC_CTRL_FLAG_A] & ien_q[`DTC_IEN_ETA];
	assign irq_b = ctrl_q[`DTC_CTRL_FLAG_B] & ien_q[`DTC_IEN_ETB];
	// pins driven only in timer mode with compare enabled
	assign pin_a_oe  = cfg_a.toggle_en & ~cfg_a.counter_sel;
	assign pin_b_oe  = cfg_b.toggle_en & ~cfg_b.counter_sel;
	assign pin_a_out = tog_a;
	assign pin_b_out = tog_b;
	// read data registered from the address-phase haddr, zero when unmapped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (hready && hsel && htrans[1] && !hwrite) begin
			unique case (haddr)
				`DTC_OFF_CTRL:  hrdata <= {24'h0, ctrl_q};
				`DTC_OFF_MODE:  hrdata <= {24'h0, mode_q};
				`DTC_OFF_LOA:   hrdata <= {24'h0, lo_a};
				`DTC_OFF_LOB:   hrdata <= {24'h0, lo_b};
				`DTC_OFF_HIA:   hrdata <= {24'h0, hi_a};
				`DTC_OFF_HIB:   hrdata <= {24'h0, hi_b};
				`DTC_OFF_CTRL2: hrdata <= {28'h0, ctrl2_q};
				`DTC_OFF_IEN:   hrdata <= {24'h0, ien_q};
				default:        hrdata <= 32'h0000_0000;
			endcase
		end
	end
	// unused synchronised levels of count pins
	logic unused_lvl;
	assign unused_lvl = cnt_a_lvl ^ cnt_b_lvl ^ hsize[0];
endmodule
`default_nettype wire

/* testbench/dtc_top_props.sv */
`timescale 1ns/1ns
`default_nettype none
// port-level checks of the dual timer
module dtc_top_props (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// bus
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// pins and requests
	input wire logic        pin_a_oe,
	input wire logic        pin_b_oe,
	input wire logic        irq_a,
	input wire logic        irq_b
);
	logic wr_q; // write data phase running
	logic rd_q; // read data phase running
	// pin enables and irq drops move only through a write data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			wr_q <= hsel & htrans[1] & hready & hwrite;
			rd_q <= hsel & htrans[1] & hready & !hwrite;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_READY: assert property (hreadyout) else $error("wait state");
	AST_RESP: assert property (!hresp) else $error("error resp");
	AST_UPPER: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_RDATA: assert property ($changed(hrdata) |-> rd_q)
		else $error("read data moved");
	AST_OE_A: assert property ($changed(pin_a_oe) |-> $past(wr_q))
		else $error("pin a oe moved");
	AST_OE_B: assert property ($changed(pin_b_oe) |-> $past(wr_q))
		else $error("pin b oe moved");
	AST_IRQ_A: assert property ($fell(irq_a) |-> $past(wr_q))
		else $error("irq a dropped");
	AST_IRQ_B: assert property ($fell(irq_b) |-> $past(wr_q))
		else $error("irq b dropped");
endmodule
bind dtc_top dtc_top_props props_u (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .pin_a_oe(pin_a_oe),
	.pin_b_oe(pin_b_oe), .irq_a(irq_a), .irq_b(irq_b)
);
`default_nettype wire

/* testbench/dtc_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
// far side of one count pin plus its gate line
module dtc_pin_model (
	// clock
	input wire logic hclk,
	// pin from timer
	input wire logic pin_out,
	input wire logic pin_oe,
	// resolved pin and gate
	output logic     pin_in,
	output logic     gate
);
	logic drv; // released line rests high on the pull-up
	assign pin_in = pin_oe ? pin_out : drv;
	initial begin
		drv = 1'b1;
		gate = 1'b0;
	end
	// n low pulses, w cycles low and w high
	task automatic pulse(input int n, input int w);
		repeat (n) begin
			drv <= 1'b0;
			repeat (w) @(posedge hclk);
			drv <= 1'b1;
			repeat (w) @(posedge hclk);
		end
	endtask
	task automatic set_gate(input logic g);
		gate <= g;
	endtask
endmodule
`default_nettype wire

/* testbench/dtc_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// register-level regression of the dual timer
module dtc_top_tb;
	logic        hclk, hresetn, hsel, hwrite;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [31:0] hwdata, hrdata, r;
	logic        hreadyout, hresp, pa_in, pa_out, pa_oe, pb_in, pb_out;
	logic        pb_oe, ga, gb, irq_a, irq_b, p, q;
	int          mismatches, cmp_count, i;
	dtc_top dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .pin_a_in(pa_in), .pin_a_out(pa_out),
		.pin_a_oe(pa_oe), .pin_b_in(pb_in), .pin_b_out(pb_out),
		.pin_b_oe(pb_oe), .gate_a_in(ga), .gate_b_in(gb),
		.irq_a(irq_a), .irq_b(irq_b)
	);
	dtc_pin_model pm_a (.hclk(hclk), .pin_out(pa_out), .pin_oe(pa_oe),
		.pin_in(pa_in), .gate(ga));
	dtc_pin_model pm_b (.hclk(hclk), .pin_out(pb_out), .pin_oe(pb_oe),
		.pin_in(pb_in), .gate(gb));
	task automatic conclude();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// bounded wait for the ready edge
	task automatic hwait();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			conclude();
		end
	endtask
	// one single word transfer, byte in the low lane
	task automatic xf(input logic w, input logic [11:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hwait();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		hwait();
		r = hrdata;
	endtask
	// look at oe and irq pins once settled
	task automatic pins(input logic [3:0] e);
		@(negedge hclk);
		chk({28'h0, pa_oe, pb_oe, irq_a, irq_b}, {28'h0, e});
		@(posedge hclk);
	endtask
	// counter run: preload, n falling edges, stop, read back
	task automatic cnt(input int t, input logic [1:0] m, input logic [15:0] v,
		input int n, input int w, input logic [15:0] e, input logic f);
		logic [11:0] o;
		logic [7:0]  rb;
		o = 12'(4 * t);
		rb = (t == 1) ? 8'h40 : 8'h10;
		xf(1'b1, 12'h010 + o, v[15:8]);
		xf(1'b1, 12'h008 + o, v[7:0]);
		xf(1'b1, 12'h004, 8'({2'b01, m}) << ((t == 1) ? 0 : 4));
		xf(1'b1, 12'h000, rb);
		if (t == 1) begin
			pm_b.pulse(n, w);
		end else begin
			pm_a.pulse(n, w);
		end
		repeat (5) @(posedge hclk);
		xf(1'b0, 12'h000, 8'h00);
		chk(r, {24'h0, rb | (f ? rb << 1 : 8'h00)});
		xf(1'b1, 12'h000, 8'h00);
		xf(1'b0, 12'h010 + o, 8'h00);
		chk(r, {24'h0, e[15:8]});
		xf(1'b0, 12'h008 + o, 8'h00);
		chk(r & ((m == 2'h0) ? 32'h1F : 32'hFF), {24'h0, e[7:0]});
	endtask
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 12'h000;
		htrans = 2'h0;
		hwdata = 32'h0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values, last one unmapped
		for (i = 0; i < 9; i++) begin
			xf(1'b0, 12'(4 * i), 8'h00);
			chk(r, 32'h0);
		end
		xf(1'b1, 12'h024, 8'h5A);
		xf(1'b0, 12'h024, 8'h00);
		chk(r, 32'h0);
		cnt(0, 2'h1, 16'hFFFE, 3, 3, 16'h0001, 1'b1);
		cnt(1, 2'h0, 16'hFF1E, 2, 2, 16'h0000, 1'b1);
		cnt(0, 2'h2, 16'h80FF, 2, 1, 16'h8081, 1'b1);
		cnt(0, 2'h3, 16'h40FE, 3, 1, 16'h4041, 1'b1);
		cnt(1, 2'h1, 16'h1234, 5, 1, 16'h1239, 1'b0);
		// gated counting, stop keeps the count
		xf(1'b1, 12'h008, 8'h00);
		xf(1'b1, 12'h004, 8'hD0);
		xf(1'b1, 12'h000, 8'h10);
		pm_a.pulse(3, 2);
		pm_a.set_gate(1'b1);
		repeat (4) @(posedge hclk);
		pm_a.pulse(2, 2);
		repeat (5) @(posedge hclk);
		xf(1'b1, 12'h000, 8'h00);
		pm_a.pulse(2, 2);
		xf(1'b1, 12'h000, 8'h10);
		pm_a.pulse(1, 2);
		repeat (5) @(posedge hclk);
		xf(1'b0, 12'h008, 8'h00);
		chk(r, 32'h3);
		// prescaler: divided, then full rate
		xf(1'b1, 12'h004, 8'h10);
		xf(1'b1, 12'h008, 8'h00);
		repeat (120) @(posedge hclk);
		xf(1'b1, 12'h000, 8'h00);
		xf(1'b0, 12'h008, 8'h00);
		chk(32'(r >= 32'd9 && r <= 32'd11), 32'h1);
		xf(1'b1, 12'h008, 8'h00);
		xf(1'b1, 12'h018, 8'h04);
		xf(1'b1, 12'h000, 8'h10);
		repeat (20) @(posedge hclk);
		xf(1'b1, 12'h000, 8'h00);
		xf(1'b0, 12'h008, 8'h00);
		chk(32'(r >= 32'd21 && r <= 32'd23), 32'h1);
		// overflow every clock toggles both driven pins
		xf(1'b1, 12'h010, 8'hFF);
		xf(1'b1, 12'h008, 8'hFF);
		xf(1'b1, 12'h014, 8'hFF);
		xf(1'b1, 12'h00C, 8'hFF);
		xf(1'b1, 12'h004, 8'h22);
		xf(1'b1, 12'h018, 8'h0F);
		xf(1'b1, 12'h000, 8'h50);
		@(negedge hclk);
		p = pa_out;
		q = pb_out;
		@(negedge hclk);
		chk({30'h0, pa_out, pb_out}, {30'h0, ~p, ~q});
		pins(4'hC);
		xf(1'b1, 12'h004, 8'h60);
		pins(4'h4);
		xf(1'b1, 12'h018, 8'h00);
		// interrupt masking and software flags
		xf(1'b1, 12'h000, 8'hA0);
		pins(4'h0);
		xf(1'b1, 12'h01C, 8'h0A);
		pins(4'h3);
		xf(1'b1, 12'h000, 8'h20);
		pins(4'h2);
		xf(1'b1, 12'h01C, 8'h08);
		pins(4'h0);
		xf(1'b0, 12'h01C, 8'h00);
		chk(r, 32'h8);
		conclude();
	end
endmodule
`default_nettype wire
